/* File: sim/can_mode_and_irq_control_tb.sv */
`timescale 1ns/1ps
module can_mode_and_irq_control_tb;
  import can_ctl_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic device_idle_i = 1'b0;
  logic [7:0] ev = 8'h00;
  logic send = 1'b0;
  logic load = 1'b0;
  logic bus_idle, rx_done, cap, act, csel, map_window_select, irq;
  logic [7:0] busy, abrt;
  logic [2:0] cur, prev;
  logic [15:0] cw, en;
  int bad_count = 0;
  int checked = 0;
  int n_cap = 0;

  initial
  begin
    forever #20 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
  begin
    if (cap === 1'b1) n_cap++;
  end

  can_node_model node_u (.mclk_i(mclk_i), .rst_i(rst_i), .send_i(send), .load_i(load),
    .abort_i(abrt), .bus_idle_o(bus_idle), .rx_done_o(rx_done), .tx_busy_o(busy));

  can_mode_and_irq_control dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .device_idle_i(device_idle_i), .bus_idle_i(bus_idle), .tx_busy_i(busy),
    .tx_abort_o(abrt), .rx_msg_done_i(rx_done), .capture_event_o(cap),
    .tx_buf_event_i(ev[0]), .rx_buf_event_i(ev[1]), .rx_overflow_event_i(ev[2]),
    .fifo_almost_full_event_i(ev[3]), .error_event_i(ev[5]), .wakeup_event_i(ev[6]),
    .invalid_msg_event_i(ev[7]), .module_active_o(act), .module_clock_select_o(csel),
    .map_window_select_o(map_window_select), .current_op_mode_o(cur), .irq_o(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task results;
    $display("mismatches %0d of %0d checks", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc

  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rdc(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, e, rdata_o);
  endtask : rdc

  function logic [15:0] exp_ctrl(input logic [15:0] w, input logic [2:0] m);
    return (w & 16'h2f09) | {8'h00, m, 5'h00};
  endfunction : exp_ctrl

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(25));
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    rdc(CTRL_ADDR, 16'h0480, "ctrl reset");
    rdc(IRQ_EN_ADDR, 16'h0000, "enable reset");
    rdc(FLAGS_ADDR, 16'h0000, "flags reset");
    rdc(4'hf, 16'h0000, "unmapped");
    for (int i = 0; i < 6; i++)
    begin
      // mode request held at config so no transition starts here
      cw = (16'($urandom) & 16'he8ff) | 16'h0400;
      wr(CTRL_ADDR, cw);
      rdc(CTRL_ADDR, exp_ctrl(cw, 3'h4), "ctrl");
      chk("clock select", 16'(cw[11]), 16'(csel));
      chk("window", 16'(cw[0]), 16'(map_window_select));
      @(posedge mclk_i);
      device_idle_i <= 1'b1;
      cyc(1);
      chk("active", 16'(!cw[13]), 16'(act));
      @(posedge mclk_i);
      device_idle_i <= 1'b0;
    end
    prev = 3'h4;
    for (int m = 0; m < 8; m++)
    begin
      cw = {5'h00, 3'(m), 8'h00};
      @(posedge mclk_i);
      send <= (m == 0);
      wr(CTRL_ADDR, cw);
      send <= 1'b0;
      cyc(3);
      chk("mode early", 16'(prev), 16'(cur));
      if (m != 5 && m != 6) prev = 3'(m);
      for (int k = 0; k < 40 && cur !== prev; k++) cyc(1);
      chk("mode", 16'(prev), 16'(cur));
      if (cur !== prev) results();
      rdc(CTRL_ADDR, exp_ctrl(cw, prev), "ctrl mode");
    end
    @(posedge mclk_i);
    load <= 1'b1;
    @(posedge mclk_i);
    load <= 1'b0;
    wr(CTRL_ADDR, cw | 16'h1000);
    #1;
    chk("abort out", 16'h00ff, 16'(abrt));
    rdc(CTRL_ADDR, exp_ctrl(cw, 3'h7) | 16'h1000, "ctrl abort");
    for (int k = 0; k < 40 && abrt !== 8'h00; k++) cyc(1);
    chk("busy at clear", 16'h0000, 16'(busy));
    chk("abort out clear", 16'h0000, 16'(abrt));
    if (abrt !== 8'h00) results();
    rdc(CTRL_ADDR, exp_ctrl(cw, 3'h7), "ctrl abort done");
    for (int c = 0; c < 2; c++)
    begin
      wr(CTRL_ADDR, cw | 16'(c << 3));
      n_cap = 0;
      send <= 1'b1;
      @(posedge mclk_i);
      send <= 1'b0;
      cyc(24);
      chk("captures", 16'(c), 16'(n_cap));
    end
    en = 16'($urandom);
    for (int p = 0; p < 2; p++)
    begin
      wr(IRQ_EN_ADDR, en);
      rdc(IRQ_EN_ADDR, en & 16'h00ef, "enable");
      for (int i = 0; i < 8; i++)
        if (i != 4)
        begin
          @(posedge mclk_i);
          ev <= 8'(1 << i);
          @(posedge mclk_i);
          ev <= 8'h00;
          #1;
          chk("irq", 16'(en[i]), 16'(irq));
          rdc(FLAGS_ADDR, 16'(1 << i), "flags");
          wr(FLAGS_ADDR, 16'(1 << i));
          rdc(FLAGS_ADDR, 16'h0000, "flags clear");
          chk("irq clear", 16'h0000, 16'(irq));
        end
      en = ~en;
    end
    results();
  end
endmodule : can_mode_and_irq_control_tb

/* File: sim/can_node_model.sv */
`timescale 1ns/1ps
// far-side stand-in: other nodes keep the bus busy during a frame, a
// received frame ends with a one-cycle done pulse, and pending transmit
// buffers drop out one per cycle once told to abort (a slow answer)
module can_node_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic send_i,
  input wire logic load_i,
  input wire logic [7:0] abort_i,
  output logic bus_idle_o,
  output logic rx_done_o,
  output logic [7:0] tx_busy_o
);
  logic [4:0] frame_reg;

  assign bus_idle_o = (frame_reg == 5'h00);

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      frame_reg <= 5'h00;
      rx_done_o <= 1'b0;
      tx_busy_o <= 8'h00;
    end
    else
    begin
      if (send_i)
        frame_reg <= 5'h12;
      else if (frame_reg != 5'h00)
        frame_reg <= frame_reg - 5'h01;
      rx_done_o <= (frame_reg == 5'h01);
      if (load_i)
        tx_busy_o <= 8'hff;
      else if (abort_i != 8'h00)
        tx_busy_o <= tx_busy_o & (tx_busy_o - 8'h01);
    end
  end
endmodule : can_node_model

/* File: src/can_ctl_pkg.sv */
package can_ctl_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map (word addresses on the plain register port)
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] FLAGS_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] IRQ_EN_ADDR = 4'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // can_control_one field positions
  localparam int IDLE_STOP_BIT = 13;
  localparam int ABORT_BIT = 12;
  localparam int CLK_SEL_BIT = 11;
  localparam int REQ_MODE_LSB = 8;
  localparam int CUR_MODE_LSB = 5;
  localparam int CAPTURE_BIT = 3;
  localparam int WINDOW_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // operating modes, shared by the requested and current mode fields
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_DISABLE = 3'h1,
    MODE_LOOPBACK = 3'h2,
    MODE_LISTEN_ONLY = 3'h3,
    MODE_CONFIG = 3'h4,
    MODE_RSVD_5 = 3'h5,
    MODE_RSVD_6 = 3'h6,
    MODE_LISTEN_ALL = 3'h7
  } op_mode_t;

  localparam op_mode_t MODE_RESET = MODE_CONFIG;
  localparam logic IDLE_STOP_RESET = 1'b0;
  localparam logic ABORT_RESET = 1'b0;
  localparam logic CLK_SEL_RESET = 1'b0;
  localparam logic CAPTURE_RESET = 1'b0;
  localparam logic WINDOW_RESET = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // can_irq_flags / can_irq_enable shared layout
  localparam int IRQ_W = 8;
  localparam int TX_BUF_BIT = 0;
  localparam int RX_BUF_BIT = 1;
  localparam int RX_OVF_BIT = 2;
  localparam int FIFO_AF_BIT = 3;
  localparam int ERROR_BIT = 5;
  localparam int WAKE_BIT = 6;
  localparam int INVALID_BIT = 7;
  localparam logic [IRQ_W-1:0] IRQ_IMPL_MASK = 8'hef;
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_FLAGS_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // mode transition timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int MODE_SETTLE_NS = 160;
  localparam int MODE_SETTLE_CYCLES = (MODE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W = 3;

  typedef enum logic [2:0] {
    ST_STABLE = 3'b001,
    ST_WAIT_IDLE = 3'b010,
    ST_SETTLE = 3'b100
  } mode_state_t;

endpackage : can_ctl_pkg

/* File: src/can_mode_and_irq_control.sv */
`timescale 1ns/1ps
module can_mode_and_irq_control #(
  parameter int NUM_TX_BUF = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [can_ctl_pkg::ADDR_W-1:0] addr_i,
  input wire logic [can_ctl_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [can_ctl_pkg::DATA_W-1:0] rdata_o,
  input wire logic device_idle_i,
  input wire logic bus_idle_i,
  input wire logic [NUM_TX_BUF-1:0] tx_busy_i,
  output logic [NUM_TX_BUF-1:0] tx_abort_o,
  input wire logic rx_msg_done_i,
  output logic capture_event_o,
  input wire logic tx_buf_event_i,
  input wire logic rx_buf_event_i,
  input wire logic rx_overflow_event_i,
  input wire logic fifo_almost_full_event_i,
  input wire logic error_event_i,
  input wire logic wakeup_event_i,
  input wire logic invalid_msg_event_i,
  output logic module_active_o,
  output logic module_clock_select_o,
  output logic map_window_select_o,
  output logic [2:0] current_op_mode_o,
  output logic irq_o
);
  import can_ctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // register state

  logic idle_stop_reg;
  logic abort_reg;
  logic clk_sel_reg;
  logic capture_en_reg;
  logic window_reg;
  op_mode_t req_mode_reg;
  op_mode_t cur_mode_reg;
  op_mode_t target_reg;
  mode_state_t state_reg;
  logic [SETTLE_CNT_W-1:0] settle_cnt_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic capture_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [IRQ_W-1:0] flags;
  logic [IRQ_W-1:0] irq_set;
  logic ctrl_wr;
  logic flags_wr;
  logic en_wr;
  logic active;
  logic all_tx_idle;
  logic req_reserved;

  assign ctrl_wr = wr_i && (addr_i == CTRL_ADDR);
  assign flags_wr = wr_i && (addr_i == FLAGS_ADDR);
  assign en_wr = wr_i && (addr_i == IRQ_EN_ADDR);
  assign active = !(device_idle_i && idle_stop_reg);
  assign all_tx_idle = ~|tx_busy_i;
  assign req_reserved = (req_mode_reg == MODE_RSVD_5) || (req_mode_reg == MODE_RSVD_6);

  ////////////////////////////////////////////////////////////////////////////////
  // control register fields

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      idle_stop_reg <= IDLE_STOP_RESET;
      clk_sel_reg <= CLK_SEL_RESET;
      capture_en_reg <= CAPTURE_RESET;
      window_reg <= WINDOW_RESET;
      req_mode_reg <= MODE_RESET;
    end
    else if (ctrl_wr)
    begin
      idle_stop_reg <= wdata_i[IDLE_STOP_BIT];
      clk_sel_reg <= wdata_i[CLK_SEL_BIT];
      capture_en_reg <= wdata_i[CAPTURE_BIT];
      window_reg <= wdata_i[WINDOW_BIT];
      req_mode_reg <= op_mode_t'(wdata_i[REQ_MODE_LSB +: 3]);
    end
  end

  // software can only set the abort; a zero written is ignored so that an
  // abort in flight cannot be cancelled halfway through the buffers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      abort_reg <= ABORT_RESET;
    else if (ctrl_wr && wdata_i[ABORT_BIT])
      abort_reg <= 1'b1;
    else if (abort_reg && all_tx_idle)
      abort_reg <= 1'b0;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_TX_BUF; g++)
    begin : g_abort
      assign tx_abort_o[g] = abort_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // mode transition: wait for bus idle, settle, then report the new mode

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_STABLE;
      settle_cnt_reg <= '0;
      target_reg <= MODE_RESET;
      cur_mode_reg <= MODE_RESET;
    end
    else
    begin
      unique case (state_reg)
        ST_STABLE:
        begin
          // reserved requests are never acted on
          if (active && !req_reserved && (req_mode_reg != cur_mode_reg))
            state_reg <= ST_WAIT_IDLE;
        end
        ST_WAIT_IDLE:
        begin
          if (req_reserved || (req_mode_reg == cur_mode_reg))
            state_reg <= ST_STABLE;
          else if (active && bus_idle_i)
          begin
            state_reg <= ST_SETTLE;
            target_reg <= req_mode_reg;
            settle_cnt_reg <= SETTLE_CNT_W'(MODE_SETTLE_CYCLES - 1);
          end
        end
        ST_SETTLE:
        begin
          // a request rewritten during settling is picked up afterwards
          if (settle_cnt_reg == '0)
          begin
            cur_mode_reg <= target_reg;
            state_reg <= ST_STABLE;
          end
          else if (active)
            settle_cnt_reg <= settle_cnt_reg - 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // capture event and interrupt sources

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      capture_reg <= 1'b0;
    else
      capture_reg <= rx_msg_done_i && capture_en_reg && active;
  end

  // wake-up still flags while stopped: that is when bus activity matters
  always_comb
  begin
    irq_set = '0;
    irq_set[TX_BUF_BIT] = tx_buf_event_i && active;
    irq_set[RX_BUF_BIT] = rx_buf_event_i && active;
    irq_set[RX_OVF_BIT] = rx_overflow_event_i && active;
    irq_set[FIFO_AF_BIT] = fifo_almost_full_event_i && active;
    irq_set[ERROR_BIT] = error_event_i && active;
    irq_set[WAKE_BIT] = wakeup_event_i;
    irq_set[INVALID_BIT] = invalid_msg_event_i && active;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      irq_en_reg <= IRQ_EN_RESET;
    else if (en_wr)
      irq_en_reg <= wdata_i[IRQ_W-1:0] & IRQ_IMPL_MASK;
  end

  irq_flag_bank #(
    .W(IRQ_W),
    .RESET_VAL(IRQ_FLAGS_RESET)
  ) u_flags (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .set_i(irq_set),
    .clr_wr_i(flags_wr),
    .clr_data_i(wdata_i[IRQ_W-1:0]),
    .mask_i(irq_en_reg),
    .flags_o(flags),
    .irq_o(irq_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read path: data valid only in the cycle after the read strobe

  always_comb
  begin
    rdata_next = '0;
    unique case (addr_i)
      CTRL_ADDR:
      begin
        rdata_next[IDLE_STOP_BIT] = idle_stop_reg;
        rdata_next[ABORT_BIT] = abort_reg;
        rdata_next[CLK_SEL_BIT] = clk_sel_reg;
        rdata_next[REQ_MODE_LSB +: 3] = req_mode_reg;
        rdata_next[CUR_MODE_LSB +: 3] = cur_mode_reg;
        rdata_next[CAPTURE_BIT] = capture_en_reg;
        rdata_next[WINDOW_BIT] = window_reg;
      end
      FLAGS_ADDR:
        rdata_next[IRQ_W-1:0] = flags;
      IRQ_EN_ADDR:
        rdata_next[IRQ_W-1:0] = irq_en_reg;
      default:
        rdata_next = '0;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      rdata_reg <= '0;
    else if (rd_i)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= '0;
  end

  assign rdata_o = rdata_reg;
  assign capture_event_o = capture_reg;
  assign module_active_o = active;
  assign module_clock_select_o = clk_sel_reg;
  assign map_window_select_o = window_reg;
  assign current_op_mode_o = cur_mode_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence abort_done_s;
    abort_reg && all_tx_idle && !(ctrl_wr && wdata_i[ABORT_BIT]);
  endsequence

  sequence settle_end_s;
    (state_reg == ST_SETTLE) && (settle_cnt_reg == '0);
  endsequence

  sequence enter_settle_s;
    (state_reg == ST_WAIT_IDLE) && !req_reserved && (req_mode_reg != cur_mode_reg) && active && bus_idle_i;
  endsequence

  abort_self_clear_a: assert property (abort_done_s |=> !abort_reg)
    else $error("abort bit not cleared after all buffers idle");

  abort_fanout_a: assert property (abort_reg && !all_tx_idle |=> abort_reg && (&tx_abort_o))
    else $error("abort dropped while a buffer still busy");

  idle_stop_a: assert property (device_idle_i && idle_stop_reg |-> !module_active_o)
    else $error("module kept running in idle with stop selected");

  clock_select_a: assert property (ctrl_wr |=> module_clock_select_o == $past(wdata_i[CLK_SEL_BIT]))
    else $error("module clock select does not follow write");

  reserved_mode_a: assert property (req_reserved && (state_reg != ST_SETTLE)
      |=> (state_reg == ST_STABLE) && $stable(cur_mode_reg))
    else $error("reserved mode request changed the mode");

  mode_report_a: assert property (rd_i && (addr_i == CTRL_ADDR)
      |=> rdata_o[CUR_MODE_LSB +: 3] == $past(cur_mode_reg))
    else $error("current mode field misreported");

  // a stop while settling freezes the count, so the commit may come later
  mode_settle_a: assert property (enter_settle_s |=> (cur_mode_reg == $past(cur_mode_reg)) [*4]
      ##1 ((cur_mode_reg == target_reg) || (state_reg == ST_SETTLE)))
    else $error("current mode updated before transition finished");

  mode_commit_a: assert property (settle_end_s |=> cur_mode_reg == $past(target_reg))
    else $error("current mode not updated at end of transition");

  capture_gate_a: assert property (rx_msg_done_i && active |=> capture_event_o == $past(capture_en_reg))
    else $error("capture event does not follow enable");

  window_sel_a: assert property (ctrl_wr |=> map_window_select_o == $past(wdata_i[WINDOW_BIT]))
    else $error("map window select does not follow write");

  rx_flag_a: assert property (rx_buf_event_i && active |=> flags[RX_BUF_BIT])
    else $error("rx buffer flag not set on event");

  tx_flag_a: assert property (tx_buf_event_i && active |=> flags[TX_BUF_BIT])
    else $error("tx buffer flag not set on event");

  irq_gate_a: assert property (irq_o == |(flags & irq_en_reg))
    else $error("interrupt output not gated by enables");

  en_upper_zero_a: assert property (rd_i && (addr_i == IRQ_EN_ADDR) |=> rdata_o[15:8] == 8'h00)
    else $error("enable register upper byte reads nonzero");

  abort_rise_a: assert property (ctrl_wr && wdata_i[ABORT_BIT] |=> &tx_abort_o)
    else $error("abort request not passed to every tx buffer");

  stopped_quiet_a: assert property (!active |=> !capture_event_o && $stable(settle_cnt_reg))
    else $error("module kept working while stopped in idle");

  mode_legal_a: assert property ((cur_mode_reg != MODE_RSVD_5) && (cur_mode_reg != MODE_RSVD_6))
    else $error("current mode shows a reserved code");

  capture_off_a: assert property (!capture_en_reg |=> !capture_event_o)
    else $error("capture event raised while disabled");

  flag_clear_a: assert property (flags_wr && !(|irq_set) |=> !(|(flags & $past(wdata_i[IRQ_W-1:0]))))
    else $error("flag not cleared by write of one");

endmodule : can_mode_and_irq_control

/* File: src/irq_flag_bank.sv */
`timescale 1ns/1ps
module irq_flag_bank #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] set_i,
  input wire logic clr_wr_i,
  input wire logic [W-1:0] clr_data_i,
  input wire logic [W-1:0] mask_i,
  output logic [W-1:0] flags_o,
  output logic irq_o
);

  logic [W-1:0] flags_reg;

  // a set arriving in the same cycle as a write-one-to-clear wins
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      flags_reg <= RESET_VAL;
    else
      flags_reg <= (flags_reg & ~({W{clr_wr_i}} & clr_data_i)) | set_i;
  end

  assign flags_o = flags_reg;
  assign irq_o = |(flags_reg & mask_i);

endmodule : irq_flag_bank
